// File: rtl/fsio_top.sv
`timescale 1ns/1ps
`default_nettype none
module fsio_top (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_b_i,
  input  wire logic                 half_cycle_tick_i,
  input  wire logic [fsio_pkg::N_IN-1:0] sense_pin_low_i,
  input  wire logic                 link_ok_i,
  input  wire logic [9:0]           rail_adc_i,
  input  wire logic [fsio_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [31:0]          reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic      [31:0]          reg_rdata_o,
  output logic      [2:0]           sink_on_o,
  output logic      [2:0]           sink_oe_o,
  output logic                      sensor_power_rail_o,
  output logic      [1:0]           rail_vsel_o,
  output logic      [fsio_pkg::N_IN-1:0] in_status_o,
  output logic                      irq_o
);
  import fsio_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [N_IN-1:0] pin_s1_r, pin_s2_r;
  logic            tick_s1_r, tick_s2_r, tick_s3_r;
  logic            link_s1_r, link_s2_r, link_d_r;
  logic [9:0]      adc_s1_r, adc_s2_r;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_s1_r  <= 4'h0;
      pin_s2_r  <= 4'h0;
      tick_s1_r <= 1'b0;
      tick_s2_r <= 1'b0;
      tick_s3_r <= 1'b0;
      link_s1_r <= 1'b0;
      link_s2_r <= 1'b0;
      link_d_r  <= 1'b0;
      adc_s1_r  <= 10'h000;
      adc_s2_r  <= 10'h000;
    end else begin
      pin_s1_r  <= sense_pin_low_i;
      pin_s2_r  <= pin_s1_r;
      tick_s1_r <= half_cycle_tick_i;
      tick_s2_r <= tick_s1_r;
      tick_s3_r <= tick_s2_r;
      link_s1_r <= link_ok_i;
      link_s2_r <= link_s1_r;
      link_d_r  <= link_s2_r;
      adc_s1_r  <= rail_adc_i;
      adc_s2_r  <= adc_s1_r;
    end
  end

  logic sample_tick;
  logic link_lost_ev;
  assign sample_tick  = tick_s2_r & ~tick_s3_r;
  assign link_lost_ev = link_d_r & ~link_s2_r;

  // ==========================================================
  // Configuration registers
  logic [N_IN-1:0]  pol_r, pol_nxt;
  logic [CNT_W-1:0] deb_t_r, deb_t_nxt, hold_t_r, hold_t_nxt, auto_t_r, auto_t_nxt;
  logic [13:0]      ocfg_r, ocfg_nxt;
  logic [1:0]       pwr_r, pwr_nxt;
  logic [7:0]       safe_r, safe_nxt;
  logic [IRQ_W-1:0] mask_r, mask_nxt, ista_r, ista_nxt;
  logic [31:0]      rdata_r, rdata_nxt;
  logic [N_OUT-1:0] cmd_wr;
  logic [N_OUT-1:0] cmd_val;
  logic [N_OUT-1:0] out_r, out_nxt;
  logic             tripped_r;
  logic [N_IN-1:0]  stat_w, stat_d_r;
  logic [N_IN-1:0]  in_used;
  logic [IRQ_W-1:0] ev;

  // Shared pins: input c vs output c, input d vs output b
  assign in_used = {~ocfg_r[F_SHARE_D], ~ocfg_r[F_SHARE_C], 2'b11};

  // All settings writable at any time over the command port
  always_comb begin
    pol_nxt    = pol_r;
    deb_t_nxt  = deb_t_r;
    hold_t_nxt = hold_t_r;
    auto_t_nxt = auto_t_r;
    ocfg_nxt   = ocfg_r;
    pwr_nxt    = pwr_r;
    safe_nxt   = safe_r;
    mask_nxt   = mask_r;
    cmd_wr     = 4'h0;
    cmd_val    = reg_wdata_i[N_OUT-1:0];
    rdata_nxt  = 32'h0000_0000;
    ista_nxt   = ista_r;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        A_POLARITY:  pol_nxt    = reg_wdata_i[N_IN-1:0];
        A_DEB_TIME:  deb_t_nxt  = reg_wdata_i[CNT_W-1:0];
        A_HOLD_TIME: hold_t_nxt = reg_wdata_i[CNT_W-1:0];
        A_AUTO_TIME: auto_t_nxt = reg_wdata_i[CNT_W-1:0];
        A_OUT_CFG:   ocfg_nxt   = reg_wdata_i[13:0];
        A_OUT_CMD:   cmd_wr     = reg_wdata_i[N_OUT+N_OUT-1:N_OUT];
        A_PWR_CFG:   pwr_nxt    = reg_wdata_i[1:0];
        A_SAFE_CFG:  safe_nxt   = reg_wdata_i[7:0];
        A_IRQ_MASK:  mask_nxt   = reg_wdata_i[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        A_POLARITY:  rdata_nxt = {28'h0, pol_r};
        A_DEB_TIME:  rdata_nxt = {16'h0, deb_t_r};
        A_HOLD_TIME: rdata_nxt = {16'h0, hold_t_r};
        A_AUTO_TIME: rdata_nxt = {16'h0, auto_t_r};
        A_OUT_CFG:   rdata_nxt = {18'h0, ocfg_r};
        A_PWR_CFG:   rdata_nxt = {30'h0, pwr_r};
        A_SAFE_CFG:  rdata_nxt = {24'h0, safe_r};
        A_IN_STAT:   rdata_nxt = {28'h0, stat_d_r};
        A_OUT_STAT:  rdata_nxt = {27'h0, tripped_r, out_r};
        A_IRQ_STAT:  rdata_nxt = {26'h0, ista_r};
        A_IRQ_MASK:  rdata_nxt = {26'h0, mask_r};
        default:     rdata_nxt = 32'h0000_0000;
      endcase
      if (reg_addr_i == A_IRQ_STAT) begin
        ista_nxt = 6'h00;
      end
    end
    // Set wins over the read-clear
    ista_nxt = ista_nxt | ev;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pol_r    <= 4'hf;
      deb_t_r  <= 16'h0001;
      hold_t_r <= 16'h0000;
      auto_t_r <= 16'h0000;
      ocfg_r   <= 14'h0000;
      pwr_r    <= 2'h0;
      safe_r   <= 8'h00;
      mask_r   <= 6'h00;
      ista_r   <= 6'h00;
      rdata_r  <= 32'h0000_0000;
    end else begin
      pol_r    <= pol_nxt;
      deb_t_r  <= deb_t_nxt;
      hold_t_r <= hold_t_nxt;
      auto_t_r <= auto_t_nxt;
      ocfg_r   <= ocfg_nxt;
      pwr_r    <= pwr_nxt;
      safe_r   <= safe_nxt;
      mask_r   <= mask_nxt;
      ista_r   <= ista_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // ==========================================================
  // Input conditioning, one filter per input
  for (genvar i = 0; i < N_IN; i++) begin : g_in
    fsio_filt_if fi ();
    assign fi.tick      = sample_tick;
    // Pin low means grounded; polarity 1 inverts
    assign fi.raw       = in_used[i] & (pin_s2_r[i] ^ pol_r[i]);
    assign fi.deb_time  = deb_t_r;
    assign fi.hold_time = hold_t_r;
    assign stat_w[i]    = fi.status;
    fsio_filter u_filt (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .f       (fi.flt)
    );
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_d_r <= 4'h0;
    end else begin
      stat_d_r <= stat_w;
    end
  end

  // ==========================================================
  // Output control with auto-off timers
  logic [CNT_W-1:0] auto_cnt_r [N_OUT];
  logic [CNT_W-1:0] auto_cnt_nxt [N_OUT];
  logic [N_OUT-1:0] accept;
  assign accept = ocfg_r[F_ACCEPT +: N_OUT] & ocfg_r[F_ADDRV +: N_OUT];

  always_comb begin
    out_nxt = out_r;
    for (int k = 0; k < N_OUT; k++) begin
      auto_cnt_nxt[k] = auto_cnt_r[k];
      if (cmd_wr[k] && accept[k]) begin
        out_nxt[k]      = cmd_val[k];
        auto_cnt_nxt[k] = auto_t_r;
      end else if (out_r[k] && ocfg_r[F_AUTOEN + k]) begin
        if (auto_cnt_r[k] == CNT_ZERO) begin
          out_nxt[k] = 1'b0;
        end else begin
          auto_cnt_nxt[k] = auto_cnt_r[k] - CNT_ONE;
        end
      end
    end
    if (link_lost_ev && safe_r[F_SAFE_MODE]) begin
      out_nxt = safe_r[F_SAFE_VAL +: N_OUT];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_r <= 4'h0;
      for (int k = 0; k < N_OUT; k++) begin
        auto_cnt_r[k] <= CNT_ZERO;
      end
    end else begin
      out_r <= out_nxt;
      for (int k = 0; k < N_OUT; k++) begin
        auto_cnt_r[k] <= auto_cnt_nxt[k];
      end
    end
  end

  // ==========================================================
  // Power rail protection and retry
  localparam logic [25:0] ON_CYC  = 26'(RETRY_ON_CYC);
  localparam logic [25:0] PER_CYC = 26'(RETRY_PER_CYC);
  logic [25:0] rt_cnt_r, rt_cnt_nxt;
  logic        tripped_nxt;
  logic [9:0]  uv_th;
  logic        uv;
  logic        rail_drive;

  always_comb begin
    unique case (pwr_r)
      FSIO_V15: uv_th = UV_15;
      FSIO_V24: uv_th = UV_24;
      default:  uv_th = UV_12;
    endcase
  end
  assign uv = adc_s2_r < uv_th;

  always_comb begin
    tripped_nxt = tripped_r;
    rt_cnt_nxt  = rt_cnt_r;
    if (!out_r[3]) begin
      tripped_nxt = 1'b0;
      rt_cnt_nxt  = 26'h0;
    end else if (!tripped_r) begin
      if (uv) begin
        tripped_nxt = 1'b1;
        rt_cnt_nxt  = 26'h0;
      end
    end else begin
      // Rail checked only at the end of its retry window, the last part of each period
      if (rt_cnt_r == PER_CYC - 26'h1) begin
        rt_cnt_nxt = 26'h0;
        if (!uv) begin
          tripped_nxt = 1'b0;
        end
      end else begin
        rt_cnt_nxt = rt_cnt_r + 26'h1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tripped_r <= 1'b0;
      rt_cnt_r  <= 26'h0;
    end else begin
      tripped_r <= tripped_nxt;
      rt_cnt_r  <= rt_cnt_nxt;
    end
  end

  // Retry window: off after a trip, then driven for the last 100 ms of each second
  assign rail_drive = out_r[3] & (~tripped_r | (rt_cnt_r >= PER_CYC - ON_CYC));

  // ==========================================================
  // Events and outputs
  assign ev = {link_lost_ev, tripped_nxt & ~tripped_r, stat_w ^ stat_d_r};

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sink_on_o           <= 3'h0;
      sink_oe_o           <= 3'h0;
      sensor_power_rail_o <= 1'b0;
    end else begin
      // Sink on means pulling low; a shared pin in input use never sinks
      sink_on_o           <= out_r[2:0] & {ocfg_r[F_SHARE_C], ocfg_r[F_SHARE_D], 1'b1};
      sink_oe_o           <= out_r[2:0] & {ocfg_r[F_SHARE_C], ocfg_r[F_SHARE_D], 1'b1};
      sensor_power_rail_o <= rail_drive;
    end
  end

  assign rail_vsel_o = pwr_r;
  assign in_status_o = stat_d_r;
  assign reg_rdata_o = rdata_r;
  assign irq_o       = |(ista_r & mask_r);
endmodule : fsio_top
`default_nettype wire

// File: shared/fsio_pkg.sv
package fsio_pkg;
  // ==========================================================
  // Sizes
  localparam int N_IN      = 4;
  localparam int N_OUT     = 4;
  localparam int CNT_W     = 16;
  localparam int ADDR_W    = 4;

  // ==========================================================
  // Register map (word addresses on the plain port)
  localparam logic [3:0] A_POLARITY  = 4'h0;
  localparam logic [3:0] A_DEB_TIME  = 4'h1;
  localparam logic [3:0] A_HOLD_TIME = 4'h2;
  localparam logic [3:0] A_OUT_CFG   = 4'h3;
  localparam logic [3:0] A_OUT_CMD   = 4'h4;
  localparam logic [3:0] A_AUTO_TIME = 4'h5;
  localparam logic [3:0] A_PWR_CFG   = 4'h6;
  localparam logic [3:0] A_IN_STAT   = 4'h7;
  localparam logic [3:0] A_OUT_STAT  = 4'h8;
  localparam logic [3:0] A_IRQ_STAT  = 4'h9;
  localparam logic [3:0] A_IRQ_MASK  = 4'ha;
  localparam logic [3:0] A_SAFE_CFG  = 4'hb;

  // ==========================================================
  // Field positions
  localparam int F_ACCEPT   = 0;   // OUT_CFG[3:0]
  localparam int F_ADDRV    = 4;   // OUT_CFG[7:4]
  localparam int F_AUTOEN   = 8;   // OUT_CFG[11:8]
  localparam int F_SHARE_C  = 12;  // OUT_CFG[12]: pin c used as output
  localparam int F_SHARE_D  = 13;  // OUT_CFG[13]: pin d used as output
  localparam int F_SAFE_MODE = 0;  // SAFE_CFG[0]
  localparam int F_SAFE_VAL  = 4;  // SAFE_CFG[7:4]
  localparam int F_PWR_SEL   = 0;  // PWR_CFG[1:0]
  localparam int I_IN_CHG    = 0;  // IRQ bits [3:0] input change
  localparam int I_PWR_TRIP  = 4;
  localparam int I_LINK_LOST = 5;
  localparam int IRQ_W       = 6;

  // ==========================================================
  // Power rail choices and undervoltage thresholds (ADC codes)
  typedef enum logic [1:0] {
    FSIO_V12 = 2'h0,
    FSIO_V15 = 2'h1,
    FSIO_V24 = 2'h2
  } fsio_vsel_t;
  localparam logic [9:0] UV_12 = 10'h180;
  localparam logic [9:0] UV_15 = 10'h1e0;
  localparam logic [9:0] UV_24 = 10'h300;

  // ==========================================================
  // Retry timing at 40 MHz
  localparam int  CLK_HZ        = 40_000_000;
  localparam int  RETRY_ON_MS   = 100;
  localparam int  RETRY_PER_MS  = 1000;
  localparam int  RETRY_ON_CYC  = CLK_HZ / 1000 * RETRY_ON_MS;
  localparam int  RETRY_PER_CYC = CLK_HZ / 1000 * RETRY_PER_MS;

  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
endpackage : fsio_pkg

// File: shared/fsio_filt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fsio_filt_if;
  import fsio_pkg::*;
  logic                tick;
  logic                raw;
  logic [CNT_W-1:0]    deb_time;
  logic [CNT_W-1:0]    hold_time;
  logic                status;
  modport ctl (output tick, output raw, output deb_time, output hold_time, input status);
  modport flt (input tick, input raw, input deb_time, input hold_time, output status);
endinterface : fsio_filt_if
`default_nettype wire

// File: rtl/fsio_filter.sv
`timescale 1ns/1ps
`default_nettype none
module fsio_filter (
  input  wire logic   mclk_i,
  input  wire logic   rst_b_i,
  fsio_filt_if.flt    f
);
  import fsio_pkg::*;

  logic [CNT_W-1:0] deb_r, deb_nxt, hold_r, hold_nxt;
  logic             stat_r, stat_nxt;

  // ==========================================================
  // Debounce then hold, counted in half-cycle ticks
  always_comb begin
    deb_nxt  = deb_r;
    hold_nxt = hold_r;
    stat_nxt = stat_r;
    if (f.tick) begin
      if (f.raw) begin
        hold_nxt = CNT_ZERO;
        if (!stat_r) begin
          if (deb_r + CNT_ONE >= f.deb_time) begin
            stat_nxt = 1'b1;
            deb_nxt  = CNT_ZERO;
          end else begin
            deb_nxt = deb_r + CNT_ONE;
          end
        end
      end else begin
        deb_nxt = CNT_ZERO;
        if (stat_r) begin
          if (hold_r >= f.hold_time) begin
            stat_nxt = 1'b0;
            hold_nxt = CNT_ZERO;
          end else begin
            hold_nxt = hold_r + CNT_ONE;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      deb_r  <= CNT_ZERO;
      hold_r <= CNT_ZERO;
      stat_r <= 1'b0;
    end else begin
      deb_r  <= deb_nxt;
      hold_r <= hold_nxt;
      stat_r <= stat_nxt;
    end
  end

  assign f.status = stat_r;
endmodule : fsio_filter
`default_nettype wire

// File: verification/fsio_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checker
module fsio_top_chk
  import fsio_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              rst_b_i,
  input wire logic              half_cycle_tick_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0]       reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [31:0]       reg_rdata_o,
  input wire logic [2:0]        sink_on_o,
  input wire logic [2:0]        sink_oe_o,
  input wire logic              sensor_power_rail_o,
  input wire logic [1:0]        rail_vsel_o,
  input wire logic [N_IN-1:0]   in_status_o,
  input wire logic              irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic [3:0] tick_age_r;
  logic [3:0] tick_age_nxt;
  // Raw tick age; loose bound covers the input synchroniser
  always_comb begin
    tick_age_nxt = tick_age_r;
    if (half_cycle_tick_i)
      tick_age_nxt = 4'h0;
    else if (tick_age_r != 4'hf)
      tick_age_nxt = tick_age_r + 4'h1;
  end
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      tick_age_r <= 4'hf;
    else
      tick_age_r <= tick_age_nxt;
  end
  chk_reset_quiet: assert property ($rose(rst_b_i) |-> sink_on_o == 3'h0
    && !sensor_power_rail_o && in_status_o == 4'h0 && rail_vsel_o == 2'h0)
    else $error("outputs not quiet after reset");
  chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data without read");
  chk_unmapped_rd: assert property (reg_rd_i && reg_addr_i > A_SAFE_CFG
    |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_oe_match: assert property (sink_oe_o == sink_on_o)
    else $error("sink enable differs from sink state");
  chk_vsel_write: assert property (reg_wr_i && reg_addr_i == A_PWR_CFG
    && reg_wdata_i[1:0] != 2'h3 |=> rail_vsel_o == $past(reg_wdata_i[1:0]))
    else $error("rail select not written");
  chk_vsel_hold: assert property (!$past(reg_wr_i) |-> $stable(rail_vsel_o))
    else $error("rail select moved without write");
  chk_in_stat_rd: assert property ($past(reg_rd_i) && $past(reg_addr_i) == A_IN_STAT
    && $stable(in_status_o) |-> reg_rdata_o == {28'h0, in_status_o})
    else $error("input status read differs from port");
  chk_status_tick: assert property ($changed(in_status_o) |-> tick_age_r < 4'h9)
    else $error("input status moved away from a tick");
  cover property (reg_rd_i && reg_addr_i == A_IN_STAT && in_status_o != 4'h0);
  cover property ($fell(sensor_power_rail_o));
  cover property ($rose(irq_o));
  cover property ($fell(sink_on_o[0]));
endmodule : fsio_top_chk
`default_nettype wire

// File: verification/fsio_mains_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Mains half-cycle ticks and controller link
module fsio_mains_model #(
  parameter int PER = 40
) (
  input  wire logic mclk_i,
  input  wire logic run_i,
  input  wire logic link_i,
  output logic      tick_o,
  output logic      link_ok_o
);
  int cnt = 0;
  initial tick_o = 1'b0;
  // Shortened period; tick idles low when not running
  always @(posedge mclk_i) begin
    cnt <= run_i ? (cnt + 1) % PER : 0;
    tick_o <= run_i && cnt >= PER / 2;
  end
  assign link_ok_o = link_i;
endmodule : fsio_mains_model
`default_nettype wire

// File: verification/fsio_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
bind fsio_top fsio_top_chk chk_u (.mclk_i, .rst_b_i, .half_cycle_tick_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sink_on_o, .sink_oe_o,
  .sensor_power_rail_o, .rail_vsel_o, .in_status_o, .irq_o);
// ==========================================
// Bench
module fsio_top_tb;
  import fsio_pkg::*;
  logic             mclk_i = 1'b0;
  logic             rst_b_i = 1'b0;
  logic             half_cycle_tick_i;
  logic             link_ok_i;
  logic             link_i = 1'b1;
  logic [3:0]       sense_pin_low_i = 4'h0;
  logic [9:0]       rail_adc_i = 10'h3ff;
  logic [3:0]       reg_addr_i = 4'h0;
  logic [31:0]      reg_wdata_i = 32'h0;
  logic             reg_wr_i = 1'b0;
  logic             reg_rd_i = 1'b0;
  logic [31:0]      reg_rdata_o;
  logic [2:0]       sink_on_o;
  logic [2:0]       sink_oe_o;
  logic             sensor_power_rail_o;
  logic [1:0]       rail_vsel_o;
  logic [3:0]       in_status_o;
  logic             irq_o;
  int               error_cnt = 0;
  int               n_tests = 0;
  initial forever #12.5 mclk_i = ~mclk_i;
  fsio_mains_model pm_u (.mclk_i, .run_i(1'b1), .link_i, .tick_o(half_cycle_tick_i),
    .link_ok_o(link_ok_i));
  fsio_top dut_u (.mclk_i, .rst_b_i, .half_cycle_tick_i, .sense_pin_low_i, .link_ok_i,
    .rail_adc_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sink_on_o,
    .sink_oe_o, .sensor_power_rail_o, .rail_vsel_o, .in_status_o, .irq_o);
  task automatic test_done;
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc
  function automatic logic [31:0] st();
    return {28'h0, in_status_o};
  endfunction : st
  function automatic logic [31:0] sk();
    return {29'h0, sink_on_o};
  endfunction : sk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(posedge mclk_i);
    d = reg_rdata_o;
  endtask : rd
  task automatic rchk(input logic [3:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask : rchk
  // Each pass waits for one fresh rising tick; settle lets the sync chain land
  task automatic ticks(input int n);
    int k;
    repeat (n) begin
      for (k = 0; half_cycle_tick_i && k < 99; k++) cyc(1);
      for (k = 0; !half_cycle_tick_i && k < 99; k++) cyc(1);
      if (k > 98) begin
        chk("tick_wait", 1, 0);
        test_done();
      end
    end
    cyc(8);
  endtask : ticks
  task automatic t_reset;
    logic [3:0]  a [9] = '{A_POLARITY, A_DEB_TIME, A_HOLD_TIME, A_OUT_CFG, A_AUTO_TIME,
                           A_PWR_CFG, A_IRQ_MASK, A_SAFE_CFG, 4'hc};
    logic [31:0] e [9] = '{32'hf, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 9; i++) rchk(a[i], e[i], "reset_val");
  endtask : t_reset
  task automatic t_filter;
    wr(A_POLARITY, 32'h0);
    wr(A_DEB_TIME, 32'h3);
    ticks(2);
    chk("idle", 32'h0, st());
    sense_pin_low_i <= 4'h1;
    ticks(2);
    chk("deb_early", 32'h0, st());
    ticks(1);
    chk("deb_done", 32'h1, st());
    rchk(A_IN_STAT, 32'h1, "in_stat_reg");
    sense_pin_low_i <= 4'h0;
    ticks(1);
    chk("drop_no_hold", 32'h0, st());
    wr(A_HOLD_TIME, 32'h2);
    sense_pin_low_i <= 4'h1;
    ticks(3);
    sense_pin_low_i <= 4'h0;
    ticks(2);
    chk("hold_kept", 32'h1, st());
    ticks(1);
    chk("hold_end", 32'h0, st());
    wr(A_POLARITY, 32'h2);
    ticks(3);
    chk("pol_float", 32'h2, st());
    wr(A_POLARITY, 32'hf);
    sense_pin_low_i <= 4'h2;
    ticks(3);
    chk("pol_ground", 32'hd, st());
  endtask : t_filter
  task automatic t_outputs;
    logic [31:0] cfg [3] = '{32'h0, 32'h300f, 32'h30f0};
    for (int i = 0; i < 3; i++) begin
      wr(A_OUT_CFG, cfg[i]);
      wr(A_OUT_CMD, 32'h11);
      cyc(3);
      chk("refused_cmd", 32'h0, sk());
    end
    wr(A_OUT_CFG, 32'h30ff);
    wr(A_OUT_CMD, 32'hff);
    cyc(3);
    chk("all_on", 32'h7, sk());
    chk("all_oe", 32'h7, {29'h0, sink_oe_o});
    chk("rail_on", 32'h1, {31'h0, sensor_power_rail_o});
    wr(A_OUT_CMD, 32'h20);
    cyc(3);
    chk("b_off", 32'h5, sk());
    sense_pin_low_i <= 4'h0;
    ticks(3);
    chk("shared_masked", 32'h3, st());
  endtask : t_outputs
  task automatic t_auto;
    wr(A_AUTO_TIME, 32'h28);
    wr(A_OUT_CFG, 32'h31ff);
    wr(A_OUT_CMD, 32'h10);
    wr(A_OUT_CMD, 32'h11);
    cyc(20);
    chk("auto_still_on", 32'h5, sk());
    cyc(30);
    chk("auto_off", 32'h4, sk());
    wr(A_OUT_CFG, 32'h30ff);
  endtask : t_auto
  task automatic t_link;
    logic [31:0] d;
    for (int m = 0; m < 2; m++) begin
      wr(A_OUT_CMD, 32'hff);
      wr(A_SAFE_CFG, {24'h0, 4'h5, 3'h0, m[0]});
      wr(A_IRQ_MASK, 32'h0);
      rd(A_IRQ_STAT, d);
      link_i <= 1'b0;
      cyc(10);
      chk("safe_sink", m ? 32'h5 : 32'h7, sk());
      chk("safe_rail", m ? 32'h0 : 32'h1, {31'h0, sensor_power_rail_o});
      chk("irq_masked", 32'h0, {31'h0, irq_o});
      wr(A_IRQ_MASK, 32'h20);
      cyc(1);
      chk("irq_raised", 32'h1, {31'h0, irq_o});
      rd(A_IRQ_STAT, d);
      chk("link_lost_bit", 32'h1, {31'h0, d[I_LINK_LOST]});
      chk("irq_cleared", 32'h0, {31'h0, irq_o});
      link_i <= 1'b1;
      cyc(10);
    end
  endtask : t_link
  task automatic t_rail;
    logic [9:0]  thr [3] = '{UV_12, UV_15, UV_24};
    logic [31:0] d;
    int          k;
    wr(A_OUT_CMD, 32'h88);
    // Raise the rail code before the select so no step dips under
    for (int v = 0; v < 3; v++) begin
      rail_adc_i <= thr[v];
      cyc(4);
      wr(A_PWR_CFG, 32'(v));
      cyc(8);
      chk("vsel", 32'(v), {30'h0, rail_vsel_o});
      chk("rail_at_thr", 32'h1, {31'h0, sensor_power_rail_o});
    end
    wr(A_IRQ_MASK, 32'h10);
    rail_adc_i <= UV_24 - 10'h1;
    for (k = 0; sensor_power_rail_o && k < 10; k++) cyc(1);
    chk("rail_trip", 32'h0, {31'h0, sensor_power_rail_o});
    rd(A_OUT_STAT, d);
    chk("trip_flag", 32'h1, {31'h0, d[4]});
    chk("irq_trip", 32'h1, {31'h0, irq_o});
    for (k = 0; !sensor_power_rail_o && k < 200; k++) cyc(1);
    chk("retry_off", 32'd200, 32'(k));
  endtask : t_rail
  initial begin
    cyc(2);
    rst_b_i <= 1'b1;
    cyc(1);
    t_reset();
    t_filter();
    t_outputs();
    t_auto();
    t_link();
    t_rail();
    test_done();
  end
endmodule : fsio_top_tb
`default_nettype wire
